/* File: core/ccdrs_pixel_burst.sv */
`default_nettype none
// Horizontal pixel clock burst: h1/h2 alternate every clock, reset gate
// pulses one clock at the start of each pixel.
module ccdrs_pixel_burst
    import ccdrs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control
    input  wire logic        start,
    input  wire logic [12:0] count,
    // Drive
    output ccdrs_horiz_s     horiz,
    output logic             busy,
    output logic             done
);
    logic [12:0] left;
    logic        half;

    // Two clocks per pixel: 50 ns period, above the 25 ns floor
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            left <= '0;
            half <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                left <= count;
                half <= 1'b0;
                busy <= (count != '0);
                done <= (count == '0);
            end
            else if (busy)
            begin
                half <= ~half;
                if (half)
                begin
                    left <= left - 13'h1;
                    if (left == 13'h1)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end

    // Reset gate one full clock (25 ns) wide, above 2.5 ns
    assign horiz.h1         = busy & ~half;         // RULE16
    assign horiz.h2         = busy & half;
    assign horiz.reset_gate = busy & ~half;         // RULE17
endmodule // ccdrs_pixel_burst
`default_nettype wire

/* File: core/ccdrs_pkg.sv */
`default_nettype none
package ccdrs_pkg;
    // Clock rate in kHz, 40 MHz reference
    localparam int CLK_KHZ = 40000;

    // Minimum times, in ns (rounded up to whole cycles)
    localparam int T_PHOTO_NS  = 6000;
    localparam int T_PED_NS    = 16000;
    localparam int T_VDLY_NS   = 2000;
    localparam int T_VXFER_NS  = 4000;
    localparam int T_HDLY_NS   = 2000;
    localparam int T_FDG_NS    = 2000;
    localparam int T_SUB_NS    = 2000;
    localparam int T_SHD_NS    = 2000;
    localparam int T_HXFER_NS  = 25;
    localparam int T_RST_PS    = 2500;   // Reset gate floor in ps, so 2.5 ns stays exact
    localparam int T_LINE2_NS  = 77900;
    localparam int T_LINE1_NS  = 140000;

    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * (CLK_KHZ / 1000) + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CYC_PD    = ns2cyc(T_PHOTO_NS);
    localparam int CYC_PED   = ns2cyc(T_PED_NS);
    localparam int CYC_VDLY  = ns2cyc(T_VDLY_NS);
    localparam int CYC_VXFER = ns2cyc(T_VXFER_NS);
    localparam int CYC_HDLY  = ns2cyc(T_HDLY_NS);
    localparam int CYC_FDG   = ns2cyc(T_FDG_NS);
    localparam int CYC_SUB   = ns2cyc(T_SUB_NS);
    localparam int CYC_SHD   = ns2cyc(T_SHD_NS);
    localparam int CYC_LINE2 = ns2cyc(T_LINE2_NS);
    localparam int CYC_LINE1 = ns2cyc(T_LINE1_NS);

    // Row/frame counts per mode
    localparam logic [12:0] VCYC_FULL_2H = 13'h0672;  // 1650 rows
    localparam logic [12:0] VCYC_FULL_1H = 13'h0cce;  // 3278 rows
    localparam logic [12:0] VCYC_QTR_2H  = 13'h0339;  // 825 rows
    localparam logic [12:0] VCYC_QTR_1H  = 13'h0667;  // 1639 rows
    localparam logic [12:0] HCYC_FULL_2O = 13'h09ad;  // 2477 pixels
    localparam logic [12:0] HCYC_FULL_1O = 13'h134f;  // 4943 pixels
    localparam logic [12:0] HCYC_QTR_2O  = 13'h04d6;  // 1238 pixels
    localparam logic [12:0] HCYC_QTR_1O  = 13'h09a7;  // 2471 pixels

    // Output configuration
    typedef enum logic [1:0] {CCDRS_QUAD, CCDRS_DUAL_AC, CCDRS_DUAL_AB, CCDRS_SINGLE} ccdrs_outcfg_e;
    // Resolution mode
    typedef enum logic [1:0] {CCDRS_FULL, CCDRS_QUARTER, CCDRS_XRANGE} ccdrs_res_e;

    // Vertical drive pins, one bit per phase, top and bottom
    typedef struct packed {
        logic [3:0] top;
        logic [3:0] bottom;
        logic       phase1_high;
    } ccdrs_vert_s;

    // Horizontal and reset drive
    typedef struct packed {
        logic h1;
        logic h2;
        logic reset_gate;
    } ccdrs_horiz_s;

    // Power sequencing enables
    typedef struct packed {
        logic protection_disable_bias;
        logic bulk_bias;
        logic other_biases;
        logic amp_supply;
        logic part_sense_resistor;
    } ccdrs_power_s;
endpackage
`default_nettype wire

/* File: core/ccdrs_sequencer.sv */
// What this block does
// RULE1: Enable other biases only after protection bias settles and bulk above 3 V.
// RULE2: No shutter pulse until protection-disable bias is stable.
// RULE3: Amplifier supply never on while bulk bias is still at 0 V.
// RULE4: Turn off part-sense circuit after its resistance has been read.
// RULE5: Full resolution quad/ac: 1650 rows; 2477 or 4943 pixels per row.
// RULE6: Full resolution ab/single: 3278 rows; 2477 or 4943 pixels per row.
// RULE7: Quarter and extended modes: 825/1639 rows, 1238/2471 pixels.
// RULE8: Row period is line transfer then the horizontal pixel burst.
// RULE9: Frame is one frame transfer plus row count times row period.
// RULE10: Without shutter, integration lasts the whole readout.
// RULE11: With shutter, integration starts at shutter pulse falling edge.
// RULE12: Integration ends when phase 1 drops from high to mid in transfer.
// RULE13: Photodiode transfer at least 6 us; pedestals at least 16 us.
// RULE14: Vertical transfer delay at least 2 us, transfer pulse 4 us.
// RULE15: Fast-dump, horizontal, shutter width and shutter delay each 2 us minimum. No fast-dump pulse is driven here.
// RULE16: Horizontal transfer period at least 25 ns.
// RULE17: Reset gate pulse at least 2.5 ns.
// RULE18: Row period at least 77.9 us dual, 140 us single register.
// RULE19: Frame period at least 129, 257 or 461 ms by readout. Not enforced here; frame length is frame transfer plus row count times row period.
// RULE20: Shutter mode exposure set by programmable row count before transfer.
// RULE21: Nested counters: frame transfer, rows, pixel burst per row.
`default_nettype none
module ccdrs_sequencer
    import ccdrs_pkg::*;
#(
    parameter int SETTLE_CYC = 40000   // Bias settle wait, 1 ms at 40 MHz
)
(
    // Clock and reset
    input  wire logic          REF_CLK_IN,
    input  wire logic          ARST_N_IN,
    // Power sequencing inputs
    input  wire logic          POWER_ON_IN,
    input  wire logic          BULK_ABOVE_3V_IN,
    input  wire logic          SENSE_DONE_IN,
    // Mode and control
    input  wire ccdrs_outcfg_e OUTCFG_IN,
    input  wire ccdrs_res_e    RES_IN,
    input  wire logic          SHUTTER_EN_IN,
    input  wire logic [12:0]   EXPOSURE_LINE_COUNT_IN,
    input  wire logic          START_IN,
    // Sensor drive
    output ccdrs_power_s       POWER_OUT,
    output ccdrs_vert_s        VERT_OUT,
    output ccdrs_horiz_s       HORIZ_OUT,
    output logic               SHUTTER_PULSE_LEVEL_OUT,
    output logic               INTEGRATING_OUT,
    // Status
    output logic               READY_OUT,
    output logic               FRAME_DONE_OUT
);
    typedef enum {P_OFF, P_PROT, P_BULK, P_ON} ccdrs_pstate_e;
    typedef enum {S_IDLE, S_LPED, S_PD, S_TPED, S_VDLY, S_VXFER, S_HDLY,
                  S_PIX, S_SHDLY, S_SUB} ccdrs_state_e;

    ccdrs_pstate_e pstate;
    ccdrs_state_e  state;
    logic [31:0]   pcnt;
    logic [31:0]   tcnt;
    logic [31:0]   rowcyc;
    logic [12:0]   row;
    logic          prot_stable;
    logic          sense_on;
    logic          integ;

    // Mode decode
    wire logic        single_h  = (OUTCFG_IN == CCDRS_DUAL_AB) || (OUTCFG_IN == CCDRS_SINGLE);
    wire logic        one_out   = (OUTCFG_IN == CCDRS_DUAL_AC) || (OUTCFG_IN == CCDRS_SINGLE);
    wire logic        full_res  = (RES_IN == CCDRS_FULL);
    wire logic [12:0] vc_full   = single_h ? VCYC_FULL_1H : VCYC_FULL_2H;  // RULE5 RULE6
    wire logic [12:0] vc_qtr    = single_h ? VCYC_QTR_1H : VCYC_QTR_2H;    // RULE7
    wire logic [12:0] hc_full   = one_out ? HCYC_FULL_1O : HCYC_FULL_2O;   // RULE5 RULE6
    wire logic [12:0] hc_qtr    = one_out ? HCYC_QTR_1O : HCYC_QTR_2O;     // RULE7
    wire logic [12:0] vert_cycles_per_frame = full_res ? vc_full : vc_qtr;
    wire logic [12:0] horiz_cycles_per_row  = full_res ? hc_full : hc_qtr;
    // Minimum row length: single-register modes need the longer line.
    // Padded rows times the row count fall short of the frame-time floors (1650 rows: 128.5 ms).
    wire logic [31:0] row_min   = single_h ? 32'(CYC_LINE1) : 32'(CYC_LINE2);  // RULE18

    // Pixel burst engine
    wire logic pix_start = (state == S_HDLY) && (tcnt == 32'(CYC_HDLY - 1));
    logic      pix_busy;
    ccdrs_pixel_burst u_pix (
        .clk    (REF_CLK_IN),
        .arst_n (ARST_N_IN),
        .start  (pix_start),
        .count  (horiz_cycles_per_row),
        .horiz  (HORIZ_OUT),
        .busy   (pix_busy),
        .done   ()
    );

    // Power sequencing: protection bias, then bulk, then the rest
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            pstate      <= P_OFF;
            pcnt        <= '0;
            prot_stable <= 1'b0;
        end
        else
        begin
            pcnt <= pcnt + 32'h1;
            unique case (pstate)
                P_OFF:
                    if (POWER_ON_IN)
                    begin
                        pstate <= P_PROT;
                        pcnt   <= '0;
                    end
                // Protection bias must settle before bulk or any shutter
                P_PROT:
                    if (pcnt >= 32'(SETTLE_CYC))
                    begin
                        pstate      <= P_BULK;
                        prot_stable <= 1'b1;
                    end
                P_BULK:
                    if (prot_stable && BULK_ABOVE_3V_IN)
                        pstate <= P_ON;                                // RULE1
                P_ON:
                    if (!POWER_ON_IN)
                    begin
                        pstate      <= P_OFF;
                        prot_stable <= 1'b0;
                    end
            endcase
        end
    end

    // Part-sense circuit on during init only; heats the sensor otherwise
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            sense_on <= 1'b0;
        else if (pstate == P_OFF)
            sense_on <= 1'b1;
        else if (SENSE_DONE_IN)
            sense_on <= 1'b0;                                          // RULE4
    end

    assign POWER_OUT.protection_disable_bias = (pstate != P_OFF);
    assign POWER_OUT.bulk_bias               = (pstate == P_BULK) || (pstate == P_ON);
    assign POWER_OUT.other_biases            = (pstate == P_ON);       // RULE1
    assign POWER_OUT.amp_supply              = (pstate == P_ON) && BULK_ABOVE_3V_IN; // RULE3
    assign POWER_OUT.part_sense_resistor     = sense_on;
    assign READY_OUT = (pstate == P_ON) && (state == S_IDLE);

    // Timing sequencer: frame transfer, then rows, with an optional shutter pulse between two rows
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            state         <= S_IDLE;
            tcnt          <= '0;
            rowcyc        <= '0;
            row           <= '0;
            FRAME_DONE_OUT <= 1'b0;
        end
        else
        begin
            tcnt           <= tcnt + 32'h1;
            rowcyc         <= rowcyc + 32'h1;
            FRAME_DONE_OUT <= 1'b0;
            unique case (state)
                S_IDLE:
                    if (START_IN && pstate == P_ON)
                    begin
                        state <= S_LPED;                               // RULE21
                        tcnt  <= '0;
                    end
                S_LPED:
                    if (tcnt == 32'(CYC_PED - 1))                      // RULE13
                    begin
                        state <= S_PD;
                        tcnt  <= '0;
                    end
                S_PD:
                    if (tcnt == 32'(CYC_PD - 1))                       // RULE13 RULE12
                    begin
                        state <= S_TPED;
                        tcnt  <= '0;
                    end
                S_TPED:
                    if (tcnt == 32'(CYC_PED - 1))                      // RULE9
                    begin
                        state  <= S_VDLY;
                        tcnt   <= '0;
                        rowcyc <= '0;
                        row    <= '0;
                    end
                S_VDLY:
                    if (tcnt == 32'(CYC_VDLY - 1))                     // RULE14
                    begin
                        state <= S_VXFER;
                        tcnt  <= '0;
                    end
                S_VXFER:
                    if (tcnt == 32'(CYC_VXFER - 1))                    // RULE14 RULE8
                    begin
                        state <= S_HDLY;
                        tcnt  <= '0;
                    end
                S_HDLY:
                    if (tcnt == 32'(CYC_HDLY - 1))                     // RULE15
                    begin
                        state <= S_PIX;
                        tcnt  <= '0;
                    end
                S_PIX:
                    // Row ends after burst and the minimum line time
                    if (!pix_busy && !pix_start && rowcyc >= row_min - 32'h1)  // RULE18 RULE8
                    begin
                        row    <= row + 13'h1;
                        rowcyc <= '0;
                        tcnt   <= '0;
                        if (row + 13'h1 == vert_cycles_per_frame)      // RULE5 RULE9
                        begin
                            FRAME_DONE_OUT <= 1'b1;
                            state <= S_IDLE;
                        end
                        else if (SHUTTER_EN_IN && prot_stable &&
                                 vert_cycles_per_frame - (row + 13'h1) == EXPOSURE_LINE_COUNT_IN) // RULE20 RULE2
                            state <= S_SHDLY;
                        else
                            state <= S_VDLY;
                    end
                S_SHDLY:
                    if (tcnt == 32'(CYC_SHD - 1))                      // RULE15
                    begin
                        state <= S_SUB;
                        tcnt  <= '0;
                    end
                S_SUB:
                    if (tcnt == 32'(CYC_SUB - 1))                      // RULE15 RULE11
                    begin
                        state <= S_VDLY;
                        tcnt  <= '0;
                    end
            endcase
        end
    end

    // Vertical phase drive; phase 1 at high level during photodiode transfer
    assign VERT_OUT.phase1_high = (state == S_PD);                     // RULE12
    assign VERT_OUT.top    = {state == S_VXFER, state == S_VDLY,
                              state == S_LPED || state == S_TPED, state == S_PD || state == S_VXFER};
    assign VERT_OUT.bottom = VERT_OUT.top;
    assign SHUTTER_PULSE_LEVEL_OUT = (state == S_SUB) && prot_stable;  // RULE2

    // Integration flag: restarts at shutter fall, ends at phase 1 fall when shutter is enabled
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            integ <= 1'b0;
        else if (state == S_PD && tcnt == 32'(CYC_PD - 1))
            integ <= !SHUTTER_EN_IN;                                   // RULE10 RULE12
        else if (state == S_SUB && tcnt == 32'(CYC_SUB - 1))
            integ <= 1'b1;                                             // RULE11
        else if (state == S_SUB)
            integ <= 1'b0;
    end
    assign INTEGRATING_OUT = integ;
endmodule // ccdrs_sequencer
`default_nettype wire

/* File: tb/ccdrs_sensor_model.sv */
`default_nettype none
// Sensor side: bulk comparator, part-sense read and photodiode exposure
module ccdrs_sensor_model
    import ccdrs_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Drive from the sequencer
    input  wire ccdrs_power_s power,
    input  wire ccdrs_vert_s  vert,
    input  wire logic         shutter,
    // Sensor answers
    output logic              bulk_above_3v,
    output logic              sense_done,
    output logic              integrating
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] bulk_dly;
    logic [1:0] sense_dly;
    logic       ph1_d;
    logic       sh_d;

    // Bulk ramps slowly but drops at once, no kinder than a real supply
    assign bulk_above_3v = bulk_dly[2];
    assign sense_done    = sense_dly[1];

    // Exposure: shutter rise drains, its falling edge starts, phase 1 fall restarts
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bulk_dly    <= 3'h0;
            sense_dly   <= 2'h0;
            ph1_d       <= 1'b0;
            sh_d        <= 1'b0;
            integrating <= 1'b0;
        end
        else
        begin
            bulk_dly  <= power.bulk_bias ? {bulk_dly[1:0], 1'b1} : 3'h0;
            sense_dly <= power.part_sense_resistor ? {sense_dly[0], 1'b1} : 2'h0;
            ph1_d     <= vert.phase1_high;
            sh_d      <= shutter;
            if (shutter && !sh_d)
                integrating <= 1'b0;
            else if (sh_d && !shutter)
                integrating <= 1'b1;
            else if (ph1_d && !vert.phase1_high)
                integrating <= 1'b1;
        end
    end
endmodule // ccdrs_sensor_model
`default_nettype wire

/* File: tb/ccdrs_sequencer_checker.sv */
`default_nettype none
module ccdrs_sequencer_checker
    import ccdrs_pkg::*;
#(
    parameter int SETTLE_CYC = 40000
)
(
    // Clock and reset
    input  wire logic         REF_CLK_IN,
    input  wire logic         ARST_N_IN,
    // Watched inputs
    input  wire logic         BULK_ABOVE_3V_IN,
    input  wire logic         SENSE_DONE_IN,
    input  wire logic         START_IN,
    // Watched outputs
    input  wire ccdrs_power_s POWER_OUT,
    input  wire ccdrs_vert_s  VERT_OUT,
    input  wire ccdrs_horiz_s HORIZ_OUT,
    input  wire logic         SHUTTER_PULSE_LEVEL_OUT,
    input  wire logic         READY_OUT
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    int prot_cnt;
    int pd_cnt;
    int sh_cnt;

    // Run lengths of held levels; bias count saturates so it cannot wrap
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            prot_cnt <= 0;
            pd_cnt  <= 0;
            sh_cnt  <= 0;
        end
        else
        begin
            prot_cnt <= !POWER_OUT.protection_disable_bias ? 0 : (prot_cnt > SETTLE_CYC) ? prot_cnt : prot_cnt + 1;
            pd_cnt  <= VERT_OUT.phase1_high ? pd_cnt + 1 : 0;
            sh_cnt  <= SHUTTER_PULSE_LEVEL_OUT ? sh_cnt + 1 : 0;
        end
    end

    sequence s_take;
        START_IN && READY_OUT;
    endsequence
    sequence s_pixel;
        HORIZ_OUT.h1 && !HORIZ_OUT.h2 ##1 HORIZ_OUT.h2 && !HORIZ_OUT.h1;
    endsequence

    property p_others_late;
        $rose(POWER_OUT.other_biases) |-> $past(BULK_ABOVE_3V_IN) && prot_cnt >= SETTLE_CYC;
    endproperty
    property p_shutter_gated;
        SHUTTER_PULSE_LEVEL_OUT |-> prot_cnt >= SETTLE_CYC;
    endproperty
    property p_amp_bulk;
        POWER_OUT.amp_supply |-> POWER_OUT.bulk_bias;
    endproperty
    property p_sense_off;
        SENSE_DONE_IN && POWER_OUT.part_sense_resistor |-> ##[1:4] !POWER_OUT.part_sense_resistor;
    endproperty
    property p_lead_ped;
        s_take |-> ##[640:642] $rose(VERT_OUT.phase1_high);
    endproperty
    property p_pd_width;
        $fell(VERT_OUT.phase1_high) |-> pd_cnt >= CYC_PD;
    endproperty
    property p_shutter_width;
        $fell(SHUTTER_PULSE_LEVEL_OUT) |-> sh_cnt >= CYC_SUB;
    endproperty
    property p_pixel;
        $rose(HORIZ_OUT.h1) |-> s_pixel;
    endproperty
    property p_reset_gate;
        HORIZ_OUT.reset_gate |-> HORIZ_OUT.h1 ##1 !HORIZ_OUT.reset_gate;
    endproperty

    a_others_late: assert property (p_others_late) else $error("other biases on too early");
    a_shutter_gated: assert property (p_shutter_gated) else $error("shutter before bias stable");
    a_amp_bulk: assert property (p_amp_bulk) else $error("amp supply without bulk bias");
    a_sense_off: assert property (p_sense_off) else $error("sense circuit left on");
    a_lead_ped: assert property (p_lead_ped) else $error("leading pedestal length wrong");
    a_pd_width: assert property (p_pd_width) else $error("photodiode transfer too short");
    a_shutter_width: assert property (p_shutter_width) else $error("shutter pulse too short");
    a_pixel: assert property (p_pixel) else $error("pixel clock pair broken");
    a_reset_gate: assert property (p_reset_gate) else $error("reset gate pulse misplaced");
endmodule // ccdrs_sequencer_checker

bind ccdrs_sequencer ccdrs_sequencer_checker #(.SETTLE_CYC(SETTLE_CYC)) chk_u (
    .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .BULK_ABOVE_3V_IN(BULK_ABOVE_3V_IN),
    .SENSE_DONE_IN(SENSE_DONE_IN), .START_IN(START_IN), .POWER_OUT(POWER_OUT), .VERT_OUT(VERT_OUT),
    .HORIZ_OUT(HORIZ_OUT), .SHUTTER_PULSE_LEVEL_OUT(SHUTTER_PULSE_LEVEL_OUT), .READY_OUT(READY_OUT));
`default_nettype wire

/* File: tb/ccdrs_sequencer_test.sv */
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module ccdrs_sequencer_test
    import ccdrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Modes: row counts and minimum row period (cycles at 40 MHz)
    localparam ccdrs_outcfg_e CFG_T [4] = '{CCDRS_QUAD, CCDRS_SINGLE, CCDRS_DUAL_AB, CCDRS_DUAL_AC};
    localparam ccdrs_res_e    RES_T [4] = '{CCDRS_FULL, CCDRS_FULL, CCDRS_QUARTER, CCDRS_XRANGE};
    localparam logic [12:0]   HC_T  [4] = '{HCYC_FULL_2O, HCYC_FULL_1O, HCYC_QTR_2O, HCYC_QTR_1O};
    localparam logic [12:0]   VC_T  [4] = '{VCYC_FULL_2H, VCYC_FULL_1H, VCYC_QTR_1H, VCYC_QTR_2H};
    localparam int            MIN_T [4] = '{3116, 5600, 5600, 3116};

    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic          power_on = 1'b0;
    ccdrs_outcfg_e outcfg = CCDRS_QUAD;
    ccdrs_res_e    res = CCDRS_FULL;
    logic          shutter_en = 1'b0;
    logic [12:0]   exp_lines = 13'h000;
    logic          start = 1'b0;
    wire logic     bulk_ok;
    wire logic     sense_done;
    wire logic     ready;
    wire logic     shutter;
    wire logic     frame_done;
    wire logic     integ_o;
    logic          sh_r = 1'b0;
    logic [12:0]   el_r = 13'h000;
    logic          exp_int [$];
    wire ccdrs_power_s power;
    wire ccdrs_vert_s  vert;
    wire ccdrs_horiz_s horiz;
    logic [12:0]   exp_nh [$];
    int            exp_min [$];
    int            fail_count = 0;
    int            n_compared = 0;
    int            cyc = 0;
    int            t_start = 0;
    int            t0 = 0;
    int            nb = 0;
    int            cnt = 0;
    int            gap = 0;
    logic          h1_d = 1'b0;

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    ccdrs_sequencer #(.SETTLE_CYC(10)) dut_u (
        .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .POWER_ON_IN(power_on), .BULK_ABOVE_3V_IN(bulk_ok),
        .SENSE_DONE_IN(sense_done), .OUTCFG_IN(outcfg), .RES_IN(res), .SHUTTER_EN_IN(shutter_en),
        .EXPOSURE_LINE_COUNT_IN(exp_lines), .START_IN(start), .POWER_OUT(power), .VERT_OUT(vert),
        .HORIZ_OUT(horiz), .SHUTTER_PULSE_LEVEL_OUT(shutter), .INTEGRATING_OUT(integ_o), .READY_OUT(ready),
        .FRAME_DONE_OUT(frame_done));

    ccdrs_sensor_model sensor_u (
        .clk(clk), .arst_n(arst_n), .power(power), .vert(vert), .shutter(shutter),
        .bulk_above_3v(bulk_ok), .sense_done(sense_done), .integrating());

    task automatic close_out();
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard: four modes of two rows each fit well below this
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            fail_count++;
            close_out();
        end
    end

    // Burst watcher: pixels per row, first-burst delay, row period
    always @(posedge clk)
    begin
        if (!arst_n)
        begin
            nb = 0;
            cnt = 0;
        end
        else if (horiz.h1 && !h1_d)
        begin
            if (cnt == 0 && nb == 0)
                `CHK("first_burst_delay", 1'b1, 1'(cyc - t_start >= 1840))
            if (cnt == 0 && nb == 1)
            begin
                `CHK("row_period", 1'b1, 1'(cyc - t0 >= exp_min[0]))
                void'(exp_min.pop_front());
            end
            if (cnt == 0)
            begin
                `CHK("integrating", exp_int[0], integ_o)
                void'(exp_int.pop_front());
                t0 = cyc;
                nb++;
            end
            cnt++;
            gap = 0;
        end
        else if (cnt > 0)
        begin
            gap++;
            if (gap == 4)
            begin
                `CHK("pixels_per_row", exp_nh[0], 13'(cnt))
                `CHK("frame_done", 1'b0, frame_done)
                void'(exp_nh.pop_front());
                cnt = 0;
            end
        end
        h1_d = horiz.h1;
    end

    // Driver: power up, start one frame per mode, reset after two rows
    initial
    begin
        void'($urandom(32'haeda));
        repeat (20) @(posedge clk);
        for (int m = 0; m < 4; m++)
        begin
            sh_r       = (m == 0) ? 1'b1 : 1'($urandom);
            el_r       = (m == 0) ? VC_T[m] - 13'h001 : 13'($urandom % 32'h400);
            arst_n     <= 1'b1;
            outcfg     <= CFG_T[m];
            res        <= RES_T[m];
            shutter_en <= sh_r;
            exp_lines  <= el_r;
            power_on   <= 1'b1;
            do @(posedge clk); while (ready !== 1'b1);
            start <= 1'b1;
            @(posedge clk);
            t_start = cyc;
            start <= 1'b0;
            exp_nh.push_back(HC_T[m]);
            exp_nh.push_back(HC_T[m]);
            exp_min.push_back(MIN_T[m]);
            // Row 0: only shutterless frames integrate; row 1 also after a shutter pulse
            exp_int.push_back(!sh_r);
            exp_int.push_back(!sh_r || (el_r == VC_T[m] - 13'h001));
            while (exp_nh.size() != 0) @(posedge clk);
            arst_n   <= 1'b0;
            power_on <= 1'b0;
            repeat (4) @(posedge clk);
        end
        close_out();
    end
endmodule // ccdrs_sequencer_test
`default_nettype wire
